// ==== src/adc_q2_pkg.sv ====
package adc_q2_pkg;
   // bus widths
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam int LOC_W = 6;
   localparam int PTR_W = 7;
   // register location and reset image
   localparam logic [ADDR_W-1:0] Q2_CTRL_ADDR = 32'h00CA000E;
   localparam logic [DATA_W-1:0] Q2_CTRL_RESET = 16'h007F;
   // field positions
   localparam int CIE_BIT = 15;
   localparam int PIE_BIT = 14;
   localparam int ARM_BIT = 13;
   localparam int MODE_HI = 12;
   localparam int MODE_LO = 8;
   localparam int RESUME_BIT = 7;
   localparam int PTR_HI = 6;
   localparam int CONT_BIT = 4;
   // trigger source codes in the low four mode bits
   localparam logic [3:0] SRC_OFF = 4'h0;
   localparam logic [3:0] SRC_SW = 4'h1;
   localparam logic [3:0] SRC_RISE = 4'h2;
   localparam logic [3:0] SRC_FALL = 4'h3;
   localparam logic [3:0] SRC_TMR_LO = 4'h4;
   localparam logic [3:0] SRC_TMR_HI = 4'hE;
   localparam logic [3:0] SRC_RSV = 4'hF;
   // timer exponent is source code plus this offset (4 -> 7)
   localparam logic [4:0] EXP_BASE = 5'h03;
   // longest timer exponent
   localparam int EXP_MAX = 17;
   // command word table
   localparam logic [PTR_W-1:0] TABLE_SIZE = 7'h40;
   localparam logic [PTR_W-1:0] LAST_WORD = 7'h3F;
   localparam logic [PTR_W-1:0] WORD_STEP = 7'h01;
   localparam logic [PTR_W-1:0] PTR_ZERO = 7'h00;
   // queue 2 sequencing states
   localparam int RUN_BIT = 1;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RUN = 4'h2,
      ST_PAUSE = 4'h4,
      ST_SUSP = 4'h8
   } q2_state_e;
endpackage

// ==== src/period_timer.sv ====
`timescale 1ns/100ps
module period_timer #(
   parameter int CNT_W = 17
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clr_i,
   input wire logic tick_i,
   input wire logic [4:0] exp_i,
   output logic expire_o
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] mask;
   logic expire_q;

   // low exp_i bits of the count select the period
   always_comb
   begin
      mask = ~({CNT_W{1'b1}} << exp_i);
   end

   // converter clock tick counter
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_q <= '0;
      else if (clr_i)
         cnt_q <= '0;
      else if (tick_i)
         cnt_q <= cnt_q + 1'b1;
   end

   // one pulse every 2**exp_i ticks
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         expire_q <= 1'b0;
      else
         expire_q <= tick_i && !clr_i && ((cnt_q & mask) == mask);
   end

   assign expire_o = expire_q;
endmodule // period_timer

// ==== src/adc_queue2_control.sv ====
// Summary of operation
// - stop mode forces the control register to 007F.
// - register always readable; writes ignored during stop mode.
// - completion enable gates an interrupt at last queue 2 word done.
// - pause enable gates an interrupt when a pause word conversion completes.
// - single-scan arm may be written with mode; it gates single-scan starts.
// - arm bit accepts writes but reads zero outside test mode.
// - hardware clears the arm bit when a single scan completes.
// - mode zero disables queue 2 entirely.
// - single-scan codes pick software, rising or falling external start.
// - codes 04 to 0E pick interval timer, two to the 7..17 ticks.
// - continuous codes pick software, rising or falling external restart.
// - codes 14 to 1E pick periodic timer, two to the 7..17 ticks.
// - resume select change applies only at end of queue or mode change.
// - resume zero restarts at queue or current subqueue start.
// - resume one restarts at the aborted command word.
// - a reported subqueue is not repeated until the whole queue ran.
// - start pointer begins queue 2 and bounds queue 1.
// - pointer 64 or more empties queue 2; queue 1 ends at word 63.
// - pointer zero gives the whole table to queue 2.
// - pointer zero ends a queue 1 scan after word 0, no conversion.
// - pointer changes reach queue 2 at its next start; 64 or more also blocks exit from pause.
// - pointer changes affect queue 1 end detection at once.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module adc_queue2_control (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [adc_q2_pkg::ADDR_W-1:0] addr_i,
   input wire logic [adc_q2_pkg::DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [adc_q2_pkg::DATA_W-1:0] rd_data_o,
   input wire logic stop_i,
   input wire logic test_mode_i,
   input wire logic ext_trig_i,
   input wire logic conv_clk_tick_i,
   input wire logic q1_active_i,
   input wire logic q1_fetch_i,
   input wire logic [adc_q2_pkg::LOC_W-1:0] q1_fetch_loc_i,
   input wire logic conv_done_i,
   input wire logic conv_pause_i,
   input wire logic conv_eoq_i,
   output logic q2_run_o,
   output logic [adc_q2_pkg::PTR_W-1:0] q2_word_addr_o,
   output logic irq_complete_o,
   output logic irq_pause_o,
   output logic q1_end_o,
   output logic q1_skip_o
);
   import adc_q2_pkg::*;

   // register fields
   logic cie_q;
   logic pie_q;
   logic arm_q;
   logic [4:0] mode_q;
   logic resume_q;
   logic [PTR_W-1:0] ptr_q;
   logic [DATA_W-1:0] rd_data_q;
   // sequencing
   q2_state_e state_q;
   logic [PTR_W-1:0] addr_q;
   logic [PTR_W-1:0] sub_q;
   logic resume_eff_q;
   logic ext_q;
   logic irq_cpl_q;
   logic irq_pau_q;
   logic q1_end_q;
   logic q1_skip_q;
   // combinational
   logic hit;
   logic wr_hit;
   logic [4:0] wmode;
   logic mode_chg;
   logic step_done;
   logic last_word;
   logic q2_end;
   logic raw_trig;
   logic trig;
   logic tmr_fire;
   logic [DATA_W-1:0] ctrl_word;

   // mode has a live trigger source
   function automatic logic mode_live(input logic [4:0] m);
      return (m[3:0] != SRC_OFF) && (m[3:0] != SRC_RSV);
   endfunction

   // timer exponent for a timer mode code
   function automatic logic [4:0] tmr_exp(input logic [4:0] m);
      return {1'b0, m[3:0]} + EXP_BASE;
   endfunction

   // last command word of queue 1 for a fetched location
   function automatic logic q1_last(input logic [LOC_W-1:0] loc,
                                    input logic [PTR_W-1:0] ptr);
      logic [PTR_W-1:0] next_loc;
      next_loc = {1'b0, loc} + WORD_STEP;
      return (ptr == PTR_ZERO) || (next_loc == TABLE_SIZE)
             || ((ptr < TABLE_SIZE) && (next_loc == ptr));
   endfunction

   // decode and write qualification
   assign hit = addr_i == Q2_CTRL_ADDR;
   assign wr_hit = wr_i && hit && !stop_i;
   assign wmode = wr_data_i[MODE_HI:MODE_LO];
   assign mode_chg = wr_hit && (wmode != mode_q);
   assign ctrl_word = {cie_q, pie_q, arm_q, mode_q, resume_q, ptr_q};

   // conversion progress of queue 2
   assign step_done = (state_q == ST_RUN) && !q1_active_i && conv_done_i;
   assign last_word = conv_eoq_i || (addr_q == LAST_WORD);
   assign q2_end = step_done && last_word;

   // interval and periodic timer
   period_timer #(
      .CNT_W(EXP_MAX)
   ) u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(mode_chg || stop_i),
      .tick_i(conv_clk_tick_i),
      .exp_i(tmr_exp(mode_q)),
      .expire_o(tmr_fire)
   );

   // trigger source select
   always_comb
   begin
      raw_trig = 1'b0;
      if (mode_q[3:0] == SRC_SW)
         raw_trig = 1'b1;
      else if (mode_q[3:0] == SRC_RISE)
         raw_trig = ext_trig_i && !ext_q;
      else if (mode_q[3:0] == SRC_FALL)
         raw_trig = !ext_trig_i && ext_q;
      else if ((mode_q[3:0] >= SRC_TMR_LO) && (mode_q[3:0] <= SRC_TMR_HI))
         raw_trig = tmr_fire;
   end

   // single scans need the arm bit; empty queue takes no trigger
   assign trig = raw_trig && mode_live(mode_q)
                 && (mode_q[CONT_BIT] || arm_q)
                 && (ptr_q < TABLE_SIZE);

   // external trigger history for edge detection
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ext_q <= 1'b0;
      else
         ext_q <= ext_trig_i;
   end

   // control register fields
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cie_q <= Q2_CTRL_RESET[CIE_BIT];
         pie_q <= Q2_CTRL_RESET[PIE_BIT];
         mode_q <= Q2_CTRL_RESET[MODE_HI:MODE_LO];
         resume_q <= Q2_CTRL_RESET[RESUME_BIT];
         ptr_q <= Q2_CTRL_RESET[PTR_HI:0];
      end
      else if (stop_i)
      begin
         cie_q <= Q2_CTRL_RESET[CIE_BIT];
         pie_q <= Q2_CTRL_RESET[PIE_BIT];
         mode_q <= Q2_CTRL_RESET[MODE_HI:MODE_LO];
         resume_q <= Q2_CTRL_RESET[RESUME_BIT];
         ptr_q <= Q2_CTRL_RESET[PTR_HI:0];
      end
      else if (wr_hit)
      begin
         cie_q <= wr_data_i[CIE_BIT];
         pie_q <= wr_data_i[PIE_BIT];
         mode_q <= wmode;
         resume_q <= wr_data_i[RESUME_BIT];
         ptr_q <= wr_data_i[PTR_HI:0];
      end
   end

   // arm bit: a write beats the hardware clear
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         arm_q <= Q2_CTRL_RESET[ARM_BIT];
      else if (stop_i)
         arm_q <= Q2_CTRL_RESET[ARM_BIT];
      else if (wr_hit)
         arm_q <= wr_data_i[ARM_BIT];
      else if (q2_end && !mode_q[CONT_BIT])
         arm_q <= 1'b0;
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rd_data_q <= '0;
      else if (rd_i && hit)
      begin
         rd_data_q <= ctrl_word;
         rd_data_q[ARM_BIT] <= arm_q && test_mode_i;
      end
      else
         rd_data_q <= '0;
   end

   // resume selection latched at end of queue or mode change
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         resume_eff_q <= Q2_CTRL_RESET[RESUME_BIT];
      else if (mode_chg)
         resume_eff_q <= wr_data_i[RESUME_BIT];
      else if ((state_q == ST_IDLE) || q2_end)
         resume_eff_q <= resume_q;
   end

   // queue 2 sequencer
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_IDLE;
         addr_q <= PTR_ZERO;
         sub_q <= PTR_ZERO;
      end
      else if (stop_i || mode_chg || !mode_live(mode_q))
         state_q <= ST_IDLE;
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (trig)
               begin
                  addr_q <= ptr_q;
                  sub_q <= ptr_q;
                  state_q <= ST_RUN;
               end
            ST_RUN:
            begin
               if (q1_active_i)
               begin
                  state_q <= ST_SUSP;
                  if (!resume_eff_q)
                     addr_q <= sub_q;
               end
               else if (conv_done_i)
               begin
                  if (last_word)
                     state_q <= ST_IDLE;
                  else if (conv_pause_i)
                  begin
                     addr_q <= addr_q + WORD_STEP;
                     sub_q <= addr_q + WORD_STEP;
                     state_q <= ST_PAUSE;
                  end
                  else
                     addr_q <= addr_q + WORD_STEP;
               end
            end
            ST_PAUSE:
               if (trig && !q1_active_i)
                  state_q <= ST_RUN;
            ST_SUSP:
               if (!q1_active_i)
                  state_q <= ST_RUN;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // interrupt requests
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_cpl_q <= 1'b0;
         irq_pau_q <= 1'b0;
      end
      else
      begin
         irq_cpl_q <= q2_end && cie_q && !stop_i;
         irq_pau_q <= step_done && conv_pause_i && pie_q && !stop_i;
      end
   end

   // queue 1 end detection against the live pointer
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q1_end_q <= 1'b0;
         q1_skip_q <= 1'b0;
      end
      else
      begin
         q1_end_q <= q1_fetch_i && q1_last(q1_fetch_loc_i, ptr_q);
         q1_skip_q <= q1_fetch_i && (ptr_q == PTR_ZERO);
      end
   end

   // outputs
   assign rd_data_o = rd_data_q;
   assign q2_run_o = state_q[RUN_BIT];
   assign q2_word_addr_o = addr_q;
   assign irq_complete_o = irq_cpl_q;
   assign irq_pause_o = irq_pau_q;
   assign q1_end_o = q1_end_q;
   assign q1_skip_o = q1_skip_q;

   // checks
   AST_STOP_FORCE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      stop_i |=> (ctrl_word == Q2_CTRL_RESET))
      else $error("stop mode did not reset control register");
   AST_READ_ANY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_i && hit) |=> (rd_data_o[PTR_HI:0] == $past(ptr_q)))
      else $error("pointer readback wrong");
   AST_ARM_READ0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_i && hit && !test_mode_i) |=> !rd_data_o[ARM_BIT])
      else $error("arm bit read as one outside test mode");
   AST_CPL_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (q2_end && !stop_i) |=> (irq_complete_o == $past(cie_q)))
      else $error("completion interrupt mismatch");
   AST_PAU_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (step_done && conv_pause_i && !stop_i) |=> (irq_pause_o == $past(pie_q)))
      else $error("pause interrupt mismatch");
   AST_NO_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !step_done |=> !irq_complete_o && !irq_pause_o)
      else $error("interrupt without conversion");
   AST_ARM_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (q2_end && !mode_q[CONT_BIT] && !wr_hit) |=> !arm_q)
      else $error("arm not cleared after single scan");
   AST_SINGLE_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_IDLE && !mode_q[CONT_BIT] && !arm_q) |=> (state_q == ST_IDLE))
      else $error("single scan started unarmed");
   AST_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode_q == 5'h00 && !wr_hit) |=> (state_q == ST_IDLE) [*2])
      else $error("disabled queue 2 left idle");
   AST_RSV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode_q[3:0] == SRC_RSV) |=> !q2_run_o)
      else $error("reserved mode ran queue 2");
   AST_EMPTY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_IDLE && ptr_q >= TABLE_SIZE) |=> (state_q == ST_IDLE))
      else $error("empty queue 2 started");
   AST_RESUME_AT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_RUN && q1_active_i && resume_eff_q && mode_live(mode_q)
       && !stop_i && !mode_chg)
      |=> (state_q == ST_SUSP) && (addr_q == $past(addr_q)))
      else $error("resume at aborted word failed");
   AST_RESTART_SUB: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_RUN && q1_active_i && !resume_eff_q && mode_live(mode_q)
       && !stop_i && !mode_chg)
      |=> (addr_q == $past(sub_q)))
      else $error("restart not at subqueue start");
   AST_Q1_SKIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (q1_fetch_i && ptr_q == PTR_ZERO) |=> q1_skip_o && q1_end_o)
      else $error("queue 1 not ended at word 0");
endmodule // adc_queue2_control

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import adc_q2_pkg::*;
   logic clk_i, rst_n_i, wr_i, rd_i, stop_i, test_mode_i, ext_trig_i, conv_clk_tick_i;
   logic q1_active_i, q1_fetch_i, conv_done_i, conv_pause_i, conv_eoq_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wr_data_i, rd_data_o;
   logic [LOC_W-1:0] q1_fetch_loc_i;
   logic [PTR_W-1:0] q2_word_addr_o;
   logic q2_run_o, irq_complete_o, irq_pause_o, q1_end_o, q1_skip_o;
   int mismatches = 0;
   int compares = 0;

   adc_queue2_control u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .stop_i(stop_i),
      .test_mode_i(test_mode_i), .ext_trig_i(ext_trig_i),
      .conv_clk_tick_i(conv_clk_tick_i),
      .q1_active_i(q1_active_i), .q1_fetch_i(q1_fetch_i), .q1_fetch_loc_i(q1_fetch_loc_i),
      .conv_done_i(conv_done_i), .conv_pause_i(conv_pause_i), .conv_eoq_i(conv_eoq_i),
      .q2_run_o(q2_run_o), .q2_word_addr_o(q2_word_addr_o), .irq_complete_o(irq_complete_o),
      .irq_pause_o(irq_pause_o), .q1_end_o(q1_end_o), .q1_skip_o(q1_skip_o)
   );

   // 250 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic final_report();
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // arm bit hidden on reads unless test mode
   function automatic logic [15:0] rb(input logic [15:0] v, input logic tm);
      return tm ? v : (v & 16'hDFFF);
   endfunction

   // queue 1 end condition from pointer and fetched location
   function automatic logic q1_end_exp(input logic [6:0] p, input logic [5:0] loc);
      return (p == 7'h00) || (p < 7'h40 && ({1'b0, loc} + 7'h01) == p) || (loc == 6'h3F);
   endfunction

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask

   task automatic wait_run(input int max, output int n);
      n = 0;
      while (q2_run_o !== 1'b1 && n < max)
      begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask

   task automatic done(input logic p, input logic e);
      @(posedge clk_i);
      conv_done_i <= 1'b1;
      conv_pause_i <= p;
      conv_eoq_i <= e;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      conv_pause_i <= 1'b0;
      conv_eoq_i <= 1'b0;
      #1;
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      final_report();
   end

   // main sequence
   initial
   begin
      logic [15:0] v, d;
      logic [4:0] c;
      logic [6:0] p;
      logic [5:0] loc;
      int n, e, x;
      logic [15:0] idle_tab[6] = '{16'h2003, 16'h2F03, 16'h3003, 16'h3F03, 16'h0103, 16'h1140};
      logic [4:0] ext_tab[4] = '{5'h02, 5'h03, 5'h12, 5'h13};
      logic [4:0] tmr_tab[4] = '{5'h04, 5'h05, 5'h14, 5'h15};
      logic [6:0] p_tab[5] = '{7'h00, 7'h05, 7'h40, 7'h40, 7'h64};
      logic [5:0] l_tab[5] = '{6'h09, 6'h04, 6'h3F, 6'h0A, 6'h3E};
      {rst_n_i, wr_i, rd_i, stop_i, test_mode_i, ext_trig_i} = '0;
      {q1_active_i, q1_fetch_i, conv_done_i, conv_pause_i, conv_eoq_i} = '0;
      conv_clk_tick_i = 1'b1;
      addr_i = '0;
      wr_data_i = '0;
      q1_fetch_loc_i = '0;
      x = $urandom(32'h15D75829);
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(Q2_CTRL_ADDR, v);
      chk("ctrl_reset", Q2_CTRL_RESET, v);
      rd(Q2_CTRL_ADDR + 32'h4, v);
      chk("unmapped_read", 16'h0000, v);
      // random register traffic, test mode toggled
      repeat (16)
      begin
         d = 16'($urandom);
         test_mode_i <= 1'($urandom);
         wr(Q2_CTRL_ADDR, d);
         wr(Q2_CTRL_ADDR ^ 32'h10, ~d);
         rd(Q2_CTRL_ADDR, v);
         chk("ctrl_rw", rb(d, test_mode_i), v);
      end
      // stop mode forces reset image and drops writes
      test_mode_i <= 1'b1;
      stop_i <= 1'b1;
      wr(Q2_CTRL_ADDR, 16'h1234);
      rd(Q2_CTRL_ADDR, v);
      chk("ctrl_stop", Q2_CTRL_RESET, v);
      stop_i <= 1'b0;
      // disabled, reserved, unarmed and empty-queue settings never start
      foreach (idle_tab[i])
      begin
         wr(Q2_CTRL_ADDR, 16'h0000);
         wr(Q2_CTRL_ADDR, idle_tab[i]);
         n = 0;
         repeat (24)
         begin
            @(posedge clk_i);
            ext_trig_i <= ~ext_trig_i;
            #1 n += int'(q2_run_o !== 1'b0);
         end
         chk("idle_mode_run", 16'h0000, 16'(n));
      end
      // external edge starts, single and continuous
      foreach (ext_tab[i])
      begin
         c = ext_tab[i];
         ext_trig_i <= c[0];
         wr(Q2_CTRL_ADDR, 16'h0000);
         wr(Q2_CTRL_ADDR, {3'b001, c, 8'h07});
         wait_run(6, n);
         chk("ext_early", 16'h0000, 16'(q2_run_o));
         @(posedge clk_i);
         ext_trig_i <= ~c[0];
         wait_run(4, n);
         chk("ext_start", 16'h0001, 16'(q2_run_o));
         chk("ext_addr", 16'h0007, 16'(q2_word_addr_o));
      end
      // interval and periodic timer starts
      foreach (tmr_tab[i])
      begin
         c = tmr_tab[i];
         wr(Q2_CTRL_ADDR, 16'h0000);
         wr(Q2_CTRL_ADDR, {3'b001, c, 8'h07});
         wait_run(600, n);
         e = 1 << (c[3:0] + 3);
         chk("timer_span", 16'h0001, 16'(n >= e - 2 && n <= e + 4));
      end
      // software single scan: completion request and arm self-clear
      wr(Q2_CTRL_ADDR, 16'h0000);
      wr(Q2_CTRL_ADDR, 16'hA105);
      wait_run(4, n);
      chk("sw_addr", 16'h0005, 16'(q2_word_addr_o));
      done(1'b0, 1'b1);
      chk("irq_complete", 16'h0001, 16'(irq_complete_o));
      rd(Q2_CTRL_ADDR, v);
      chk("arm_cleared", 16'h8105, v);
      chk("single_stays_idle", 16'h0000, 16'(q2_run_o));
      // every enable pairing on pause and end of queue
      for (e = 0; e < 4; e++)
      begin
         wr(Q2_CTRL_ADDR, 16'h0000);
         wr(Q2_CTRL_ADDR, {e[0], e[1], 1'b0, 5'h11, 8'h14});
         wait_run(4, n);
         done(1'b1, 1'b0);
         chk("irq_pause", 16'(e[1]), 16'(irq_pause_o));
         chk("irq_cpl_mid", 16'h0000, 16'(irq_complete_o));
         wait_run(4, n);
         done(1'b0, 1'b1);
         chk("irq_cpl", 16'(e[0]), 16'(irq_complete_o));
         chk("irq_pause_end", 16'h0000, 16'(irq_pause_o));
      end
      // suspension by queue 1 and resume point
      for (e = 0; e < 2; e++)
      begin
         wr(Q2_CTRL_ADDR, 16'h0000);
         wr(Q2_CTRL_ADDR, 16'h110A | 16'(e << 7));
         wait_run(4, n);
         done(1'b0, 1'b0);
         chk("step_addr", 16'h000B, 16'(q2_word_addr_o));
         @(posedge clk_i);
         q1_active_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         #1 chk("suspended", 16'h0000, 16'(q2_run_o));
         @(posedge clk_i);
         q1_active_i <= 1'b0;
         wait_run(4, n);
         chk("resume_addr", e ? 16'h000B : 16'h000A, 16'(q2_word_addr_o));
      end
      // pointer and resume changes mid-queue wait for the next start
      wr(Q2_CTRL_ADDR, 16'h0000);
      wr(Q2_CTRL_ADDR, 16'h1120);
      wait_run(4, n);
      done(1'b1, 1'b0);
      wr(Q2_CTRL_ADDR, 16'h11B0);
      done(1'b0, 1'b0);
      chk("mid_ptr_addr", 16'h0022, 16'(q2_word_addr_o));
      @(posedge clk_i);
      q1_active_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      q1_active_i <= 1'b0;
      wait_run(4, n);
      chk("subqueue_restart", 16'h0021, 16'(q2_word_addr_o));
      // pointer zero starts queue 2 at the first table word
      wr(Q2_CTRL_ADDR, 16'h0000);
      wr(Q2_CTRL_ADDR, 16'h2100);
      wait_run(4, n);
      chk("zero_ptr_start", 16'h0100, {7'h00, q2_run_o, 1'b0, q2_word_addr_o});
      // queue 1 end detection against the live pointer
      for (e = 0; e < 25; e++)
      begin
         p = (e < 5) ? p_tab[e] : 7'($urandom);
         loc = (e < 5) ? l_tab[e] : ((e % 2) ? 6'(p - 7'h01) : 6'($urandom));
         wr(Q2_CTRL_ADDR, {9'h000, p});
         @(posedge clk_i);
         q1_fetch_i <= 1'b1;
         q1_fetch_loc_i <= loc;
         @(posedge clk_i);
         q1_fetch_i <= 1'b0;
         #1 chk("q1_end", 16'(q1_end_exp(p, loc)), 16'(q1_end_o));
         chk("q1_skip", 16'(p == 7'h00), 16'(q1_skip_o));
      end
      final_report();
   end
endmodule // testbench
